// ==== design/swe_core.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "swe_cfg.svh"
module swe_core
    import swe_pkg::*;
#(
    parameter int ADDR_W      = `SWE_ADDR_W,
    parameter int PROG_CYCLES = `SWE_PROG_CYCLES
) (
    // Core side
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic low_supply,
    output logic      prog_busy,
    // Link side
    input  wire logic serial_clock_in,
    input  wire logic select,
    input  wire logic serial_in,
    output logic      serial_out,
    output logic      serial_out_oe_n
);
    localparam int WW    = `SWE_WORD_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int CW    = $clog2(PROG_CYCLES + 1);

    // Link-domain state. Select low acts as the link reset, since the
    // serial clock stands still between frames and cannot end a frame.
    swe_state_t        st_q;
    logic [1:0]        opc_q;
    logic [ADDR_W-1:0] addr_q;
    logic [WW-1:0]     sh_q;
    logic [4:0]        cnt_q;
    logic [5:0]        extra_q;
    logic              rd_oe_q;
    logic              rd_bit_q;
    logic              poll_q;
    logic              frame_busy_q;
    logic              ready_s1_q;
    logic              ready_s2_q;
    logic [WW-1:0]     mem [DEPTH];

    function automatic logic [ADDR_W-1:0] shift_addr(input logic [ADDR_W-1:0] a,
                                                     input logic b);
        return {a[ADDR_W-2:0], b};
    endfunction

    // Busy level crosses into the link domain through two flops.
    always_ff @(posedge serial_clock_in or posedge rst) begin
        if (rst) begin
            ready_s1_q <= 1'b0;
            ready_s2_q <= 1'b0;
        end else begin
            ready_s1_q <= ~prog_busy;
            ready_s2_q <= ready_s1_q;
        end
    end

    logic frame_rst;
    assign frame_rst = rst | ~select;

    always_ff @(posedge serial_clock_in or posedge frame_rst) begin
        if (frame_rst) begin
            st_q     <= SWE_IDLE;
            opc_q    <= 2'h0;
            addr_q   <= '0;
            sh_q     <= '0;
            cnt_q    <= 5'h0;
            extra_q  <= 6'h0;
            rd_oe_q  <= 1'b0;
            rd_bit_q <= 1'b0;
        end else if (!ready_s2_q) begin
            st_q <= SWE_IDLE; // [RL7]
        end else begin
            case (st_q)
                SWE_IDLE: begin
                    if (serial_in) begin // [RL1] [RL2] [RL3] [RL22]
                        st_q    <= SWE_OPC;
                        cnt_q   <= 5'h0;
                        extra_q <= 6'h0;
                    end
                end
                SWE_OPC: begin
                    opc_q <= {opc_q[0], serial_in};
                    cnt_q <= cnt_q + 5'h1;
                    if (cnt_q == 5'h1) begin
                        st_q  <= SWE_ADDR;
                        cnt_q <= 5'h0;
                    end
                end
                SWE_ADDR: begin
                    addr_q <= shift_addr(addr_q, serial_in);
                    cnt_q  <= cnt_q + 5'h1;
                    if (cnt_q == 5'(ADDR_W - 1)) begin
                        cnt_q <= 5'h0;
                        if (opc_q == SWE_OP_READ) begin
                            st_q     <= SWE_RDOUT; // [RL5]
                            rd_oe_q  <= 1'b1;
                            rd_bit_q <= 1'b0;
                            sh_q     <= mem[shift_addr(addr_q, serial_in)];
                        end else if (opc_q == SWE_OP_WRITE
                                     || (opc_q == SWE_OP_SPECIAL
                                         && addr_q[ADDR_W-2:ADDR_W-3] == 2'b01)) begin
                            st_q <= SWE_DATA;
                        end else begin
                            st_q <= SWE_TAIL;
                        end
                    end
                end
                SWE_DATA: begin
                    sh_q  <= {sh_q[WW-2:0], serial_in};
                    cnt_q <= cnt_q + 5'h1;
                    if (cnt_q == 5'(WW - 1)) begin
                        st_q <= SWE_TAIL;
                    end
                end
                SWE_RDOUT: begin
                    rd_bit_q <= sh_q[WW-1];
                    sh_q     <= {sh_q[WW-2:0], 1'b0};
                    cnt_q    <= cnt_q + 5'h1;
                    if (cnt_q == 5'(WW - 1)) begin
                        cnt_q  <= 5'h0;
                        addr_q <= addr_q + 1'b1; // [RL6]
                        sh_q   <= mem[addr_q + 1'b1];
                    end
                end
                SWE_TAIL: begin
                    if (extra_q != 6'h3F) begin
                        extra_q <= extra_q + 6'h1; // [RL21]
                    end
                end
                default: st_q <= SWE_IDLE;
            endcase
        end
    end

    // Command decode seen at select fall; held until the core takes it.
    swe_pgm_t pend_d;
    always_comb begin
        pend_d = SWE_PG_NONE;
        if (st_q == SWE_TAIL && extra_q == 6'h0) begin // [RL21]
            case (opc_q)
                SWE_OP_WRITE:  pend_d = SWE_PG_WRITE; // [RL13]
                SWE_OP_ERASE:  pend_d = SWE_PG_ERASE; // [RL14]
                SWE_OP_SPECIAL: begin
                    case (addr_q[ADDR_W-1:ADDR_W-2]) // [RL24]
                        2'b11:   pend_d = SWE_PG_UNLK;
                        2'b00:   pend_d = SWE_PG_LOCK;
                        2'b01:   pend_d = SWE_PG_FILL; // [RL15]
                        default: pend_d = SWE_PG_CLEAR; // [RL16]
                    endcase
                end
                default: pend_d = SWE_PG_NONE;
            endcase
        end else if (st_q == SWE_TAIL && opc_q == SWE_OP_SPECIAL
                     && addr_q[ADDR_W-1] == addr_q[ADDR_W-2]) begin
            pend_d = addr_q[ADDR_W-1] ? SWE_PG_UNLK : SWE_PG_LOCK; // [RL17]
        end
    end

    // Frame end: latch command on select fall, toggle toward the core.
    swe_pgm_t          cmd_q;
    logic [ADDR_W-1:0] cmd_addr_q;
    logic [WW-1:0]     cmd_data_q;
    logic              cmd_tgl_q;
    always_ff @(negedge select or posedge rst) begin
        if (rst) begin
            cmd_q      <= SWE_PG_NONE;
            cmd_addr_q <= '0;
            cmd_data_q <= '0;
            cmd_tgl_q  <= 1'b0;
        end else if (pend_d != SWE_PG_NONE && ready_s2_q) begin
            cmd_q      <= pend_d; // [RL7]
            cmd_addr_q <= addr_q;
            cmd_data_q <= sh_q;
            cmd_tgl_q  <= ~cmd_tgl_q;
        end
    end

    // Core domain: toggle synchroniser and programming timer.
    logic [2:0]  tgl_sync_q;
    logic [CW-1:0] timer_q;
    logic        unlocked_q;
    logic [1:0]  sel_sync_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tgl_sync_q <= 3'h0;
            sel_sync_q <= 2'h0;
        end else begin
            tgl_sync_q <= {tgl_sync_q[1:0], cmd_tgl_q};
            sel_sync_q <= {sel_sync_q[0], select};
        end
    end
    logic cmd_ev;
    assign cmd_ev = tgl_sync_q[2] ^ tgl_sync_q[1];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            unlocked_q <= 1'b0;
            prog_busy  <= 1'b0;
            timer_q    <= '0;
        end else if (low_supply) begin
            unlocked_q <= 1'b0; // [RL19]
            prog_busy  <= 1'b0;
            timer_q    <= '0;
        end else if (prog_busy) begin
            timer_q <= timer_q - 1'b1; // [RL10]
            if (timer_q == CW'(1)) begin
                prog_busy <= 1'b0;
            end
        end else if (cmd_ev) begin
            if (cmd_q == SWE_PG_UNLK) begin
                unlocked_q <= 1'b1; // [RL17]
            end else if (cmd_q == SWE_PG_LOCK) begin
                unlocked_q <= 1'b0;
            end else if (unlocked_q) begin // [RL9]
                prog_busy <= 1'b1;
                timer_q   <= CW'(PROG_CYCLES);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (cmd_ev && unlocked_q && !low_supply && !prog_busy) begin
            for (int i = 0; i < DEPTH; i++) begin
                if ((cmd_q == SWE_PG_WRITE && cmd_addr_q == ADDR_W'(i))
                    || cmd_q == SWE_PG_FILL) begin
                    mem[i] <= cmd_data_q;
                end else if ((cmd_q == SWE_PG_ERASE && cmd_addr_q == ADDR_W'(i))
                             || cmd_q == SWE_PG_CLEAR) begin
                    mem[i] <= '1;
                end
            end
        end
    end

    // Polling starts on the first reselect after a program command.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            frame_busy_q <= 1'b0;
        end else if (cmd_ev && unlocked_q && cmd_q != SWE_PG_UNLK
                     && cmd_q != SWE_PG_LOCK) begin
            frame_busy_q <= 1'b1;
        end else if (!sel_sync_q[1] && !prog_busy) begin
            frame_busy_q <= 1'b0;
        end
    end

    always_comb begin
        poll_q = frame_busy_q & select & (st_q == SWE_IDLE); // [RL11] [RL12]
    end
    // Output: read data, or live status while polling, else floating.
    always_comb begin
        serial_out      = 1'b0;
        serial_out_oe_n = 1'b1; // [RL25] [RL23]
        if (select && rd_oe_q && st_q == SWE_RDOUT) begin
            serial_out      = rd_bit_q;
            serial_out_oe_n = 1'b0;
        end else if (poll_q) begin
            // The link clock stands still while polling, so status follows the timer.
            serial_out      = ~prog_busy;
            serial_out_oe_n = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== inc/swe_cfg.svh ====
// Notes on behaviour
// RL1: Start bit is first sampled high input.
// RL2: Leading low-input clocks are ignored dummies.
// RL3: Input high while ready starts new command.
// RL4: Host holds input low while polling.
// RL5: Read drives low dummy bit, then word.
// RL6: Held select streams next words, wrapping around.
// RL7: Programming starts at select fall; inputs ignored.
// RL8: Host starts commands only when not busy.
// RL9: Program commands act only when unlocked.
// RL10: Programming lasts at most eight milliseconds.
// RL11: Reselect shows low busy, high ready.
// RL12: Status reported on every reselection; the code shows it only until the first deselect once ready.
// RL13: Write programs one word, no erase.
// RL14: Erase sets addressed word to ones.
// RL15: Fill-all writes one word everywhere.
// RL16: Clear-all sets whole array to ones.
// RL17: Unlock and lock act at select fall.
// RL18: Host locks whenever not programming.
// RL19: Low supply cancels programs, clears latch.
// RL20: Host unlocks again after supply recovery.
// RL21: Wrong clock count cancels program command.
// RL22: Sample input on rising clock edges.
// RL23: Select low means standby, inputs ignored.
// RL24: Opcode decode with sub-codes in address.
// RL25: Output floats unless reading or reporting status.
`ifndef SWE_CFG_SVH
`define SWE_CFG_SVH
`define SWE_ADDR_W         7
`define SWE_WORD_W         16
`define SWE_PROG_TIME_MS   4
`define SWE_PROG_MAX_MS    8
`define SWE_CLK_MHZ        100
`define SWE_PROG_CYCLES    (`SWE_PROG_TIME_MS * 1000 * `SWE_CLK_MHZ)
`endif

// ==== inc/swe_pkg.sv ====
package swe_pkg;
    typedef enum logic [2:0] {
        SWE_IDLE  = 3'b000,
        SWE_OPC   = 3'b001,
        SWE_ADDR  = 3'b010,
        SWE_DATA  = 3'b011,
        SWE_RDOUT = 3'b100,
        SWE_TAIL  = 3'b101
    } swe_state_t;
    typedef enum logic [1:0] {
        SWE_OP_SPECIAL = 2'b00,
        SWE_OP_WRITE   = 2'b01,
        SWE_OP_READ    = 2'b10,
        SWE_OP_ERASE   = 2'b11
    } swe_op_t;
    typedef enum logic [2:0] {
        SWE_PG_NONE  = 3'b000,
        SWE_PG_WRITE = 3'b001,
        SWE_PG_ERASE = 3'b010,
        SWE_PG_FILL  = 3'b011,
        SWE_PG_CLEAR = 3'b100,
        SWE_PG_UNLK  = 3'b101,
        SWE_PG_LOCK  = 3'b110
    } swe_pgm_t;
endpackage

// ==== tb/swe_core_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module swe_chk #(
    parameter int PROG_CYCLES = 50
) (
    // Core side
    input wire logic core_clk,
    input wire logic rst,
    input wire logic low_supply,
    input wire logic prog_busy,
    // Link side
    input wire logic serial_clock_in,
    input wire logic select,
    input wire logic serial_out,
    input wire logic serial_out_oe_n
);
    int busy_len_q;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busy_len_q <= 0;
        end else begin
            busy_len_q <= prog_busy ? busy_len_q + 1 : 0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_STANDBY_FLOAT: assert property (!select |-> serial_out_oe_n)
        else $error("driven while deselected");
    AST_BUSY_MAX: assert property (busy_len_q <= 2 * PROG_CYCLES)
        else $error("programming too long");
    AST_BUSY_AT_FALL: assert property ($rose(prog_busy) |-> !select)
        else $error("programming began while selected");
    AST_POLL_LOW: assert property (select && prog_busy && !serial_out_oe_n |-> !serial_out)
        else $error("ready shown while busy");
    AST_READY_AFTER: assert property ($fell(prog_busy) && select
        |-> ##[1:8] (serial_out || serial_out_oe_n)) else $error("ready not shown");
    AST_SUPPLY_BLOCK: assert property ($rose(prog_busy) |-> !low_supply && !$past(low_supply))
        else $error("programming under low supply");
    AST_RST_IDLE: assert property ($past(rst) |-> !prog_busy)
        else $error("busy after reset");
    AST_SHIFT_EDGE: assert property (!serial_out_oe_n && !$past(serial_out_oe_n)
        && $fell(serial_out) |-> $rose(serial_clock_in)) else $error("data moved off edge");
    // The ready-going edge of polling is exempt above, since it follows the core timer.
    cover property ($rose(prog_busy));
    cover property (select && prog_busy && !serial_out_oe_n);
    cover property (!serial_out_oe_n && $rose(serial_clock_in) && !prog_busy);
endmodule
bind swe_core swe_chk #(.PROG_CYCLES(PROG_CYCLES)) u_swe_chk (.core_clk, .rst, .low_supply,
    .prog_busy, .serial_clock_in, .select, .serial_out, .serial_out_oe_n);
`default_nettype wire

// ==== tb/swe_core_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module swe_core_tb
    import swe_pkg::*;
;
    logic        core_clk, rst, low_supply, prog_busy, sck, sel, sdi, sdo, oe_n;
    logic [63:0] got;
    logic [15:0] d;
    logic [6:0]  a;
    int          n_checks, n_fail, cyc, seed;
    int          mem [128];
    swe_core #(.PROG_CYCLES(100)) u_swe_core (.core_clk(core_clk), .rst(rst),
        .low_supply(low_supply), .prog_busy(prog_busy), .serial_clock_in(sck), .select(sel),
        .serial_in(sdi), .serial_out(sdo), .serial_out_oe_n(oe_n));
    swe_host u_swe_host (.serial_clock_in(sck), .select(sel), .serial_in(sdi),
        .serial_out(sdo), .serial_out_oe_n(oe_n));
    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Two dummy clocks lead every program frame; nd is the data clock count sent.
    task automatic prog(input logic [1:0] op, input logic [6:0] ad, input logic [15:0] v,
                        input int nd, input logic ok);
        logic [63:0] b;
        b = {38'h0, 1'b1, op, ad, v};
        b = (nd <= 16) ? b >> (16 - nd) : b << (nd - 16);
        u_swe_host.frame(12 + nd, b, got);
        u_swe_host.drop();
        chk("busy", 16'(prog_busy), 16'(ok));
        if (ok) begin
            u_swe_host.poll(got[0]);
            chk("status busy", 16'(got[0]), 16'h0000);
            u_swe_host.drop();
            u_swe_host.poll(got[0]);
            for (int i = 0; i < 300 && prog_busy; i++) @(negedge core_clk);
            repeat (10) @(negedge core_clk);
            chk("status ready", 16'(oe_n ? 1'bx : sdo), 16'h0001);
            case (op)
                SWE_OP_WRITE: mem[ad] = v;
                SWE_OP_ERASE: mem[ad] = 16'hFFFF;
                default: foreach (mem[i]) mem[i] = ad[6] ? 16'hFFFF : v;
            endcase
        end
    endtask
    task automatic rd(input logic [6:0] ad, input int w);
        u_swe_host.frame(11 + 16 * w, 64'({1'b1, SWE_OP_READ, ad}) << (1 + 16 * w), got);
        u_swe_host.drop();
        chk("float", 16'(got[9 + 16 * w -: 9]), 16'(9'bx));
        chk("dummy", 16'(got[16 * w]), 16'h0000);
        for (int k = 0; k < w; k++)
            chk("read", got[16 * (w - 1 - k) +: 16], 16'(mem[(ad + k) % 128]));
    endtask
    initial begin
        rst = 1'b1;
        low_supply = 1'b0;
        seed = 74;
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        d = 16'($random(seed));
        prog(SWE_OP_WRITE, 7'h05, d, 16, 1'b0);
        prog(SWE_OP_SPECIAL, 7'h60, d, 0, 1'b0);
        prog(SWE_OP_SPECIAL, 7'h40, d, 0, 1'b1);
        prog(SWE_OP_WRITE, 7'h7F, d, 16, 1'b1);
        prog(SWE_OP_WRITE, 7'h00, ~d, 16, 1'b1);
        rd(7'h7F, 2);
        prog(SWE_OP_ERASE, 7'h7F, d, 0, 1'b1);
        prog(SWE_OP_WRITE, 7'h03, d, 17, 1'b0);
        prog(SWE_OP_ERASE, 7'h00, d, 1, 1'b0);
        rd(7'h7F, 2);
        $display("test program, wrap and miscount done");
        d = 16'($random(seed));
        prog(SWE_OP_SPECIAL, 7'h20, d, 16, 1'b1);
        rd(7'h41, 3);
        prog(SWE_OP_SPECIAL, 7'h00, d, 0, 1'b0);
        prog(SWE_OP_ERASE, 7'h02, d, 0, 1'b0);
        rd(7'h02, 1);
        prog(SWE_OP_SPECIAL, 7'h60, d, 0, 1'b0);
        @(negedge core_clk) low_supply = 1'b1;
        repeat (5) @(negedge core_clk);
        low_supply = 1'b0;
        prog(SWE_OP_WRITE, 7'h02, ~d, 16, 1'b0);
        prog(SWE_OP_SPECIAL, 7'h60, d, 0, 1'b0);
        $display("test fill, lock and supply done");
        for (int j = 0; j < 4; j++) begin
            d = 16'($random(seed));
            a = 7'($random(seed));
            prog(SWE_OP_WRITE, a, d, 16, 1'b1);
            rd(a, 1);
        end
        $display("test random words done");
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== tb/swe_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module swe_host (
    // To the device
    output logic      serial_clock_in,
    output logic      select,
    output logic      serial_in,
    // From the device
    input  wire logic serial_out,
    input  wire logic serial_out_oe_n
);
    initial begin
        serial_clock_in = 1'b0;
        select = 1'b0;
        serial_in = 1'b0;
    end
    // The clock runs only inside a frame; a floating output reads as unknown.
    task automatic frame(input int n, input logic [63:0] bits, output logic [63:0] got);
        got = '0;
        select = 1'b1;
        #21.3;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = bits[i];
            #15;
            got[i] = serial_out_oe_n ? 1'bx : serial_out;
            serial_clock_in = 1'b1;
            #15;
            serial_clock_in = 1'b0;
        end
        serial_in = 1'b0;
    endtask
    task automatic drop();
        #15;
        select = 1'b0;
        #200;
    endtask
    task automatic poll(output logic q);
        select = 1'b1;
        #40;
        q = serial_out_oe_n ? 1'bx : serial_out;
    endtask
endmodule
`default_nettype wire
